// *** temp_fmt_pkg.sv ***
/*
  Constants for the temperature result formatter: data widths, clamp
  limits, range offset, rate codes and conversion timing.
  Assumes a 10 MHz system clock.
*/
package temp_fmt_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int RAW_W = 16;
  localparam int FRAC_BITS = 4;
  localparam int RATE_W = 4;
  localparam logic [7:0] STD_MIN_CODE = 8'h00;
  localparam logic [7:0] STD_MAX_CODE = 8'h7F;
  localparam logic [7:0] EXT_OFFSET = 8'h40;
  localparam logic [7:0] EXT_MAX_CODE = 8'hFF;
  localparam logic [3:0] FRAC_PAD = 4'h0;
  // Conversion rate codes: 0.0625/s up to 32/s
  localparam logic [RATE_W-1:0] RATE_0P0625 = 4'h0;
  localparam logic [RATE_W-1:0] RATE_16 = 4'h8;
  localparam logic [RATE_W-1:0] RATE_32 = 4'h9;
  localparam logic [RATE_W-1:0] RATE_MAX = 4'h9;
  localparam logic [RATE_W-1:0] RATE_RESET = RATE_16;
  // Period at 32/s in ns; slower codes double it per step
  localparam longint FAST_PERIOD_NS = 31_250_000;
  localparam longint FAST_PERIOD_CYC = FAST_PERIOD_NS * CLK_HZ
                                       / 1_000_000_000;
  localparam int PERIOD_W = 32;
  localparam int SHUTDOWN_SCL_MAX_KHZ = 2500;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_LOC = 5'b00010,
    ST_REM = 5'b00100,
    ST_WAIT = 5'b01000,
    ST_SHDN = 5'b10000
  } conv_state_type;
endpackage

// *** temp_result_formatter.sv ***
/*
  Temperature result formatter: paces local then remote conversions,
  formats each signed raw sample into whole-degree and fraction bytes,
  and holds one result per channel.
  Assumes the analog front end returns a signed 1/16 degree sample with
  a one-cycle done pulse, on the same clock; the serial interface and
  configuration logic live outside and drive range, rate and shutdown.
*/
// Summary of operation
// - Separate local and remote stored results
// - Twelve magnitude bits, 0.0625 degree steps
// - Standard range clamps below zero to 00h
// - Standard range saturates above 127 to 7Fh
// - Range bit high selects extended encoding
// - Range change applies from next local conversion
// - Extended range adds 40h to whole degrees
// - Extended spans -64 to 191, clamped to 00h/FFh
// - Rates include 0.0625, 16, 32 per second
// - Reset rate is 16 per second
// - Shutdown stops conversions, bus stays alive
// - Result is whole byte plus fraction byte
// - Fraction left-justified in bits 7..4
module temp_result_formatter
  import temp_fmt_pkg::*;
#(
  parameter longint PERIOD_32_CYC = FAST_PERIOD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic range_ext,
  input wire logic [RATE_W-1:0] rate_sel,
  input wire logic rate_wr,
  input wire logic shutdown,
  input wire logic adc_done,
  input wire logic signed [RAW_W-1:0] adc_data,
  output logic adc_start,
  output logic adc_remote,
  output logic [7:0] local_whole,
  output logic [7:0] local_frac,
  output logic [7:0] remote_whole,
  output logic [7:0] remote_frac,
  output logic [RATE_W-1:0] rate_cur,
  output logic busy
);

  // Whole degrees of a sample, sign kept
  function automatic logic signed [RAW_W-1:0] whole_deg(
    input logic signed [RAW_W-1:0] raw);
    whole_deg = raw >>> FRAC_BITS;
  endfunction

  // Sample lies under the lowest code of the selected range
  function automatic logic below_span(
    input logic signed [RAW_W-1:0] raw, input logic ext);
    if (ext) begin
      below_span = whole_deg(raw) < -RAW_W'(signed'({1'b0, EXT_OFFSET}));
    end else begin
      below_span = raw < 0;
    end
  endfunction

  // Sample lies over the highest code of the selected range
  function automatic logic above_span(
    input logic signed [RAW_W-1:0] raw, input logic ext);
    logic signed [RAW_W-1:0] top;
    if (ext) begin
      top = RAW_W'(signed'({1'b0, EXT_MAX_CODE - EXT_OFFSET}));
    end else begin
      top = RAW_W'(signed'({1'b0, STD_MAX_CODE}));
    end
    above_span = whole_deg(raw) > top;
  endfunction

  // Formats one raw sample into whole degrees per selected range
  function automatic logic [7:0] fmt_whole(
    input logic signed [RAW_W-1:0] raw, input logic ext);
    logic signed [RAW_W-1:0] deg;
    deg = whole_deg(raw);
    if (ext) begin
      deg = deg + RAW_W'(signed'({1'b0, EXT_OFFSET}));
    end
    if (below_span(raw, ext)) begin
      fmt_whole = STD_MIN_CODE;
    end else if (above_span(raw, ext)) begin
      fmt_whole = ext ? EXT_MAX_CODE : STD_MAX_CODE;
    end else begin
      fmt_whole = deg[7:0];
    end
  endfunction

  // Fraction nibble left-justified; clamped values carry no fraction
  function automatic logic [7:0] fmt_frac(
    input logic signed [RAW_W-1:0] raw, input logic ext);
    fmt_frac = {raw[FRAC_BITS-1:0], FRAC_PAD};
    if (below_span(raw, ext) || above_span(raw, ext)) begin
      fmt_frac = 8'h00;
    end
  endfunction

  conv_state_type state_r, state_nxt;
  logic [PERIOD_W-1:0] tick_r, tick_nxt;
  logic [RATE_W-1:0] rate_r, rate_nxt;
  logic range_r, range_nxt;
  logic start_r, start_nxt;
  logic remote_r, remote_nxt;
  logic [7:0] lw_r, lw_nxt;
  logic [7:0] lf_r, lf_nxt;
  logic [7:0] rw_r, rw_nxt;
  logic [7:0] rf_r, rf_nxt;
  logic [PERIOD_W-1:0] period;

  // Period doubles for every step below the fastest code
  always_comb begin
    period = PERIOD_W'(PERIOD_32_CYC) << (RATE_MAX - rate_r);
  end

  // Conversion sequencer and result capture
  always_comb begin
    state_nxt = state_r;
    tick_nxt = tick_r;
    rate_nxt = rate_r;
    range_nxt = range_r;
    start_nxt = 1'b0;
    remote_nxt = remote_r;
    lw_nxt = lw_r;
    lf_nxt = lf_r;
    rw_nxt = rw_r;
    rf_nxt = rf_r;
    if (rate_wr && rate_sel <= RATE_MAX) begin
      rate_nxt = rate_sel;
    end
    if (tick_r != '0) begin
      tick_nxt = tick_r - PERIOD_W'(1);
    end
    unique case (state_r)
      ST_IDLE: begin
        if (shutdown) begin
          state_nxt = ST_SHDN;
        end else begin
          range_nxt = range_ext;
          // Minus two: the idle cycle belongs to the period
          tick_nxt = period - PERIOD_W'(2);
          start_nxt = 1'b1;
          remote_nxt = 1'b0;
          state_nxt = ST_LOC;
        end
      end
      ST_LOC: begin
        if (adc_done) begin
          lw_nxt = fmt_whole(adc_data, range_r);
          lf_nxt = fmt_frac(adc_data, range_r);
          start_nxt = 1'b1;
          remote_nxt = 1'b1;
          state_nxt = ST_REM;
        end
      end
      ST_REM: begin
        if (adc_done) begin
          rw_nxt = fmt_whole(adc_data, range_r);
          rf_nxt = fmt_frac(adc_data, range_r);
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (shutdown) state_nxt = ST_SHDN;
        else if (tick_r == '0) state_nxt = ST_IDLE;
      end
      ST_SHDN: begin
        tick_nxt = '0;
        if (!shutdown) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State registers with synchronous reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= ST_IDLE;
      tick_r <= '0;
      rate_r <= RATE_RESET;
      range_r <= 1'b0;
      start_r <= 1'b0;
      remote_r <= 1'b0;
      lw_r <= STD_MIN_CODE;
      lf_r <= 8'h00;
      rw_r <= STD_MIN_CODE;
      rf_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      tick_r <= tick_nxt;
      rate_r <= rate_nxt;
      range_r <= range_nxt;
      start_r <= start_nxt;
      remote_r <= remote_nxt;
      lw_r <= lw_nxt;
      lf_r <= lf_nxt;
      rw_r <= rw_nxt;
      rf_r <= rf_nxt;
    end
  end

  // Busy flag registered from the next state
  logic busy_r, busy_nxt;
  always_comb begin
    busy_nxt = (state_nxt == ST_LOC) || (state_nxt == ST_REM);
  end
  always_ff @(posedge clk_sys) begin
    if (rst) busy_r <= 1'b0;
    else busy_r <= busy_nxt;
  end

  assign adc_start = start_r;
  assign adc_remote = remote_r;
  assign local_whole = lw_r;
  assign local_frac = lf_r;
  assign remote_whole = rw_r;
  assign remote_frac = rf_r;
  assign rate_cur = rate_r;
  assign busy = busy_r;
endmodule

// *** adc_model.sv ***
/* Front end model: answers each start after one or three cycles.
   Assumes the bench sets the samples and the delay. */
module adc_model (
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic adc_start,
  input wire logic adc_remote,
  input wire logic signed [15:0] loc_val,
  input wire logic signed [15:0] rem_val,
  output logic adc_done,
  output logic signed [15:0] adc_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] d = 0;
  logic r = 0;
  always @(posedge clk_sys)
    {d, r} <= {d[1:0], adc_start, adc_start ? adc_remote : r};
  assign adc_done = slow ? d[2] : d[0];
  assign adc_data = (r ? rem_val : loc_val) ^ {16{!adc_done}};
endmodule

// *** trf_assertions.sv ***
/* Checker on the formatter ports.
   Assumes one clock, synchronous reset. */
module trf_assertions import temp_fmt_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rate_wr,
  input wire logic shutdown,
  input wire logic adc_done,
  input wire logic adc_start,
  input wire logic adc_remote,
  input wire logic busy,
  input wire logic [RATE_W-1:0] rate_sel,
  input wire logic [RATE_W-1:0] rate_cur,
  input wire logic [7:0] local_whole,
  input wire logic [7:0] local_frac,
  input wire logic [7:0] remote_whole,
  input wire logic [7:0] remote_frac
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_start_pulse: assert property
    (adc_start |=> !adc_start) else $error("long start");
  a_remote_next: assert property
    (adc_done && busy && !adc_remote |=> adc_start && adc_remote)
    else $error("no remote");
  a_busy_clear: assert property
    (adc_done && busy && adc_remote |=> !busy) else $error("busy stuck");
  a_result_hold: assert property
    (!adc_done |=> $stable({local_whole, local_frac, remote_whole,
    remote_frac})) else $error("result moved");
  a_rate_load: assert property
    (rate_wr && rate_sel <= RATE_MAX |=> rate_cur == $past(rate_sel))
    else $error("rate lost");
  a_rate_keep: assert property
    (!(rate_wr && rate_sel <= RATE_MAX) |=> $stable(rate_cur))
    else $error("rate moved");
  a_rate_reset: assert property
    ($fell(rst) |-> rate_cur == RATE_RESET) else $error("reset rate");
  a_shut_stop: assert property
    ((shutdown && !busy)[*2] |=> !adc_start) else $error("shut start");
  a_frac_pad: assert property
    (local_frac[3:0] == FRAC_PAD && remote_frac[3:0] == FRAC_PAD)
    else $error("fraction pad");
  c_remote: cover property (adc_done && adc_remote);
  c_bad_rate: cover property (rate_wr && rate_sel > RATE_MAX);
  c_shut: cover property (shutdown && !busy);
endmodule
bind temp_result_formatter trf_assertions chk_i (
  .clk_sys(clk_sys),
  .rst(rst),
  .rate_wr(rate_wr),
  .shutdown(shutdown),
  .adc_done(adc_done),
  .adc_start(adc_start),
  .adc_remote(adc_remote),
  .busy(busy),
  .rate_sel(rate_sel),
  .rate_cur(rate_cur),
  .local_whole(local_whole),
  .local_frac(local_frac),
  .remote_whole(remote_whole),
  .remote_frac(remote_frac)
);

// *** temp_result_formatter_tb_top.sv ***
/* Bench: random samples in both ranges, rate codes, shutdown.
   Assumes adc_model as front end and the bound checker. */
module temp_result_formatter_tb_top import temp_fmt_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst = 1, range_ext = 0, rate_wr = 0, shutdown = 0;
  logic slow = 0, adc_done, adc_start, adc_remote, busy;
  logic [RATE_W-1:0] rate_sel = 0, rate_cur;
  logic signed [RAW_W-1:0] adc_data, loc_val = 0, rem_val = 0;
  logic [7:0] local_whole, local_frac, remote_whole, remote_frac;
  int n_errors = 0, checked = 0, cnt = 0, gap, n, seed = 32'h3DB8A9D0;
  localparam int P32 = 20;
  wire lst = adc_start === 1'b1 && adc_remote === 1'b0;
  temp_result_formatter #(
    .PERIOD_32_CYC(P32)
  ) dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .range_ext(range_ext),
    .rate_sel(rate_sel),
    .rate_wr(rate_wr),
    .shutdown(shutdown),
    .adc_done(adc_done),
    .adc_data(adc_data),
    .adc_start(adc_start),
    .adc_remote(adc_remote),
    .local_whole(local_whole),
    .local_frac(local_frac),
    .remote_whole(remote_whole),
    .remote_frac(remote_frac),
    .rate_cur(rate_cur),
    .busy(busy)
  );
  adc_model fe (
    .clk_sys(clk_sys),
    .slow(slow),
    .adc_start(adc_start),
    .adc_remote(adc_remote),
    .loc_val(loc_val),
    .rem_val(rem_val),
    .adc_done(adc_done),
    .adc_data(adc_data)
  );
  initial forever #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cnt <= lst ? 1 : cnt + 1;
  function automatic logic [15:0] fmt(int t, bit e);
    int w = (t >>> 4) + (e ? 64 : 0);
    if (w < 0) return 0;
    if (w > (e ? 255 : 127)) return {e ? 8'hFF : 8'h7F, 8'h00};
    return {w[7:0], t[3:0], 4'h0};
  endfunction
  task chk(input logic [15:0] got, exp);
    checked++;
    if (got !== exp) n_errors++;
    if (got !== exp) $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
  endtask
  task tally_and_finish;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic run(input bit e);
    int lv = $random(seed) % 4000, rv = $random(seed) % 4000;
    {loc_val, rem_val, slow, range_ext} <= {16'(lv), 16'(rv), lv[0], e};
    n = 0;
    do @(posedge clk_sys); while (!lst && n++ < 30000);
    gap = cnt;
    range_ext <= !e;
    do @(posedge clk_sys); while (busy !== 1'b0 && n++ < 30000);
    chk(n < 30000, 1);
    chk({local_whole, local_frac}, fmt(lv, e));
    chk({remote_whole, remote_frac}, fmt(rv, e));
  endtask
  task automatic setrate(logic [3:0] c, logic [3:0] x);
    {rate_sel, rate_wr} <= {c, 1'b1};
    @(posedge clk_sys);
    rate_wr <= 0;
    @(posedge clk_sys);
    chk(rate_cur, x);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    chk(rate_cur, RATE_16);
    chk({local_whole, local_frac}, 16'h0000);
    chk({remote_whole, remote_frac}, 16'h0000);
    for (int i = 0; i < 20; i++) run(i[1]);
    chk(gap inside {[40:42]}, 1);
    setrate(4'h9, 4'h9);
    run(0);
    run(1);
    chk(gap inside {[20:22]}, 1);
    setrate(4'hF, 4'h9);
    shutdown <= 1;
    repeat (300) @(posedge clk_sys);
    chk(cnt >= 300, 1);
    setrate(4'h0, 4'h0);
    shutdown <= 0;
    run(0);
    run(1);
    chk(16'(gap), 16'(P32 << 9));
    tally_and_finish;
  end
  initial begin
    #3000000;
    n_errors++;
    tally_and_finish;
  end
endmodule
